// [logic/gpc_regs.vh]
// register offsets, field positions and reset values of the gigabit control block
`ifndef GPC_REGS_VH
`define GPC_REGS_VH
`define GPC_IDX_GIG_CTRL      4'h9
`define GPC_IDX_GIG_STAT      4'ha
`define GPC_IDX_EXT_CTRL      4'hd
`define GPC_IDX_EXT_ADDR_DATA 4'he
`define GPC_ADDR_GIG_CTRL     12'h024
`define GPC_ADDR_GIG_STAT     12'h028
`define GPC_ADDR_EXT_CTRL     12'h034
`define GPC_ADDR_EXT_AD       12'h038
`define GPC_ADDR_CMD          12'h040
`define GPC_ADDR_IRQ_STAT     12'h044
`define GPC_ADDR_IRQ_MASK     12'h048
`define GPC_ADDR_PHY_STAT     12'h04c
`define GPC_CTRL_RST          16'h0200
`define GPC_TM_NORMAL         3'h0
`define GPC_TM_WAVEFORM       3'h1
`define GPC_TM_JIT_MASTER     3'h2
`define GPC_TM_JIT_SLAVE      3'h3
`define GPC_TM_DISTORT        3'h4
`define GPC_FN_ADDR           2'h0
`define GPC_FN_DATA           2'h1
`define GPC_FN_INC_RW         2'h2
`define GPC_FN_INC_WR         2'h3
`define GPC_TM_HI             15
`define GPC_TM_LO             13
`define GPC_MS_EN_BIT         12
`define GPC_MS_VAL_BIT        11
`define GPC_PORT_BIT          10
`define GPC_FD_BIT            9
`define GPC_HD_BIT            8
`define GPC_CNT_MAX           8'hff
`define GPC_IRQ_W             3
`endif

// [logic/gpc_sync.v]
// three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/1ps
module gpc_sync #(
	parameter W = 1
) (
	input  wire         i_clk_sys,
	input  wire         i_sys_rst,
	input  wire [W-1:0] i_async,
	output reg  [W-1:0] o_sync
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;

	// first stage feeds only the second; output moves when stages two and three agree
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			s1_q   <= {W{1'b0}};
			s2_q   <= {W{1'b0}};
			s3_q   <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			o_sync <= (s2_q & s3_q) | (o_sync & (s2_q | s3_q));
		end
	end
endmodule // gpc_sync

// [logic/gpc_ctrl_status.v]
// gigabit phy control/status registers and extended access control on apb
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "gpc_regs.vh"

// Contract
// - test mode 000 normal, 001-100 tests
// - jitter tests clock transmit from receive pin
// - negotiation restart zeroes test mode field
// - role and duplex writes pend until trigger
// - manual mode: value 1 master, 0 slave
// - port type preference ignored when manual
// - separate duplex advertise bits, full resets one
// - config fault latches, clears on status read
// - resolved role reported read only
// - local and remote receiver ok bits
// - partner gigabit duplex abilities reported
// - idle errors count, clear on read, saturate
// - function 00 address, 01 data; device address
// - 10 increments on all, 11 writes only
// - address/data reaches address or data location
module gpc_ctrl_status (
	input  wire        i_clk_sys,
	input  wire        i_sys_rst,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output reg  [31:0] o_prdata,
	output wire        o_pslverr,
	input  wire        i_ms_fault,
	input  wire        i_ms_resolved_master,
	input  wire        i_local_rx_ok,
	input  wire        i_remote_rx_ok,
	input  wire        i_lp_gig_fd,
	input  wire        i_lp_gig_hd,
	input  wire        i_idle_error,
	input  wire        i_copper_link_up,
	input  wire        i_power_down,
	input  wire        i_rx_clk_pin,
	input  wire        i_tx_clk_local,
	input  wire [4:0]  i_target_device_address,
	input  wire [15:0] i_ext_rdata,
	output reg  [2:0]  o_test_mode,
	output wire        o_tx_clk_sel_rx,
	output wire        o_tx_clk,
	output reg         o_ms_manual_en,
	output reg         o_ms_manual_master,
	output wire        o_want_master,
	output reg         o_adv_gig_fd,
	output reg         o_adv_gig_hd,
	output reg         o_soft_reset,
	output reg         o_an_restart,
	output reg         o_ext_wr,
	output reg         o_ext_rd,
	output reg         o_ext_is_addr,
	output reg  [15:0] o_ext_wdata,
	output reg  [15:0] o_ext_addr,
	output wire [4:0]  o_target_device_address,
	output wire        o_irq
);
	// pin-side status passes the synchroniser
	wire [7:0] st_s;
	gpc_sync #(.W(8)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_ms_fault, i_ms_resolved_master, i_local_rx_ok, i_remote_rx_ok,
		             i_lp_gig_fd, i_lp_gig_hd, i_copper_link_up, i_power_down}),
		.o_sync    (st_s)
	);
	// synchronised status, one name per pin
	wire fault_s  = st_s[7];
	wire master_s = st_s[6];
	wire lrx_s    = st_s[5];
	wire rrx_s    = st_s[4];
	wire lp_fd_s  = st_s[3];
	wire lp_hd_s  = st_s[2];
	wire link_s   = st_s[1];
	wire pdown_s  = st_s[0];

	reg        idle_s1_q;
	reg        idle_s2_q;
	reg        idle_s3_q;
	reg        idle_lvl_q;
	reg        idle_d1_q;
	// idle error strobe arrives as a level pulse from the line side; each rising edge is one event
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			idle_s1_q  <= 1'b0;
			idle_s2_q  <= 1'b0;
			idle_s3_q  <= 1'b0;
			idle_lvl_q <= 1'b0;
			idle_d1_q  <= 1'b0;
		end else begin
			idle_s1_q <= i_idle_error;
			idle_s2_q <= idle_s1_q;
			idle_s3_q <= idle_s2_q;
			if (idle_s2_q == idle_s3_q)
				idle_lvl_q <= idle_s3_q;
			idle_d1_q <= idle_lvl_q;
		end
	end
	wire idle_evt = idle_lvl_q & ~idle_d1_q;

	// apb decode; zero wait states
	wire acc    = i_psel & i_penable;
	wire wr     = acc & i_pwrite;
	wire rd     = acc & ~i_pwrite;
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `GPC_ADDR_GIG_CTRL) || (a == `GPC_ADDR_GIG_STAT) ||
			            (a == `GPC_ADDR_EXT_CTRL) || (a == `GPC_ADDR_EXT_AD) ||
			            (a == `GPC_ADDR_CMD) || (a == `GPC_ADDR_IRQ_STAT) ||
			            (a == `GPC_ADDR_IRQ_MASK) || (a == `GPC_ADDR_PHY_STAT);
		end
	endfunction
	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~is_mapped(i_paddr);

	wire wr_ctrl = wr & (i_paddr == `GPC_ADDR_GIG_CTRL);
	wire rd_stat = rd & (i_paddr == `GPC_ADDR_GIG_STAT);
	wire wr_ext  = wr & (i_paddr == `GPC_ADDR_EXT_CTRL);
	wire acc_ad  = acc & (i_paddr == `GPC_ADDR_EXT_AD);
	wire wr_cmd  = wr & (i_paddr == `GPC_ADDR_CMD);
	wire wr_isc  = wr & (i_paddr == `GPC_ADDR_IRQ_STAT);
	wire wr_msk  = wr & (i_paddr == `GPC_ADDR_IRQ_MASK);

	// command word: bit0 soft reset, bit1 negotiation restart
	wire cmd_srst = wr_cmd & i_pwdata[0];
	wire cmd_anr  = wr_cmd & i_pwdata[1];

	// power-down exit while link is down also applies pending bits
	reg  pdown_d1_q;
	always @(posedge i_clk_sys) begin
		if (i_sys_rst)
			pdown_d1_q <= 1'b0;
		else
			pdown_d1_q <= pdown_s;
	end
	wire pd_exit = pdown_d1_q & ~pdown_s & ~link_s;
	wire apply   = cmd_srst | cmd_anr | pd_exit;

	// control register: shadow holds pending writes, live fields drive the core
	reg [15:0] ctrl_q;
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ctrl_q             <= `GPC_CTRL_RST;
			o_test_mode        <= `GPC_TM_NORMAL;
			o_ms_manual_en     <= 1'b0;
			o_ms_manual_master <= 1'b0;
			o_adv_gig_fd       <= 1'b1;
			o_adv_gig_hd       <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q      <= i_pwdata[15:0];
				o_test_mode <= i_pwdata[`GPC_TM_HI:`GPC_TM_LO];
			end
			if (cmd_anr) begin
				ctrl_q[`GPC_TM_HI:`GPC_TM_LO] <= `GPC_TM_NORMAL;
				o_test_mode                   <= `GPC_TM_NORMAL;
			end
			// pending role and duplex bits become live only here
			if (apply) begin
				o_ms_manual_en     <= ctrl_q[`GPC_MS_EN_BIT];
				o_ms_manual_master <= ctrl_q[`GPC_MS_VAL_BIT];
				o_adv_gig_fd       <= ctrl_q[`GPC_FD_BIT];
				o_adv_gig_hd       <= ctrl_q[`GPC_HD_BIT];
			end
		end
	end
	// applied port type kept apart from the shadow so reads show the written value
	reg port_live_q;
	always @(posedge i_clk_sys) begin
		if (i_sys_rst)
			port_live_q <= 1'b0;
		else if (apply)
			port_live_q <= ctrl_q[`GPC_PORT_BIT];
	end
	// preference ignored under manual configuration
	assign o_want_master = o_ms_manual_en ? o_ms_manual_master : port_live_q;

	// jitter tests clock transmit from the receive pin; a glitch-free mux is the core's job
	assign o_tx_clk_sel_rx = (o_test_mode == `GPC_TM_JIT_MASTER) ||
	                         (o_test_mode == `GPC_TM_JIT_SLAVE);
	assign o_tx_clk = o_tx_clk_sel_rx ? i_rx_clk_pin : i_tx_clk_local;

	// command pulses to the core, one cycle each
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_soft_reset <= 1'b0;
			o_an_restart <= 1'b0;
		end else begin
			o_soft_reset <= cmd_srst;
			o_an_restart <= cmd_anr;
		end
	end

	// fault latch and saturating idle counter; set beats read clear
	reg       fault_q;
	reg [7:0] idle_cnt_q;
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			fault_q    <= 1'b0;
			idle_cnt_q <= 8'h00;
		end else begin
			if (fault_s)
				fault_q <= 1'b1;
			else if (rd_stat)
				fault_q <= 1'b0;
			if (rd_stat)
				idle_cnt_q <= idle_evt ? 8'h01 : 8'h00;
			else if (idle_evt && idle_cnt_q != `GPC_CNT_MAX)
				idle_cnt_q <= idle_cnt_q + 8'h01;
		end
	end
	wire [15:0] stat_w = {fault_q, master_s, lrx_s, rrx_s, lp_fd_s, lp_hd_s,
	                      2'b00, idle_cnt_q};

	// extended access control and address/data port
	reg [1:0] func_q;
	assign o_target_device_address = i_target_device_address;
	always @(posedge i_clk_sys) begin
		if (i_sys_rst)
			func_q <= `GPC_FN_ADDR;
		else if (wr_ext)
			func_q <= i_pwdata[15:14];
	end
	wire ad_addr = (func_q == `GPC_FN_ADDR);
	// increment policy depends on function and direction
	wire ad_inc  = (func_q == `GPC_FN_INC_RW) ||
	               ((func_q == `GPC_FN_INC_WR) && i_pwrite);
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_ext_addr    <= 16'h0000;
			o_ext_wr      <= 1'b0;
			o_ext_rd      <= 1'b0;
			o_ext_is_addr <= 1'b0;
			o_ext_wdata   <= 16'h0000;
		end else begin
			o_ext_wr      <= acc_ad & i_pwrite & ~ad_addr;
			o_ext_rd      <= acc_ad & ~i_pwrite & ~ad_addr;
			o_ext_is_addr <= acc_ad & i_pwrite & ad_addr;
			if (acc_ad & i_pwrite)
				o_ext_wdata <= i_pwdata[15:0];
			if (acc_ad & i_pwrite & ad_addr)
				o_ext_addr <= i_pwdata[15:0];
			else if (acc_ad & ~ad_addr & ad_inc)
				o_ext_addr <= o_ext_addr + 16'h0001;
		end
	end

	// interrupts: fault, idle error, receiver loss
	wire [`GPC_IRQ_W-1:0] irq_st;
	reg  [`GPC_IRQ_W-1:0] irq_mk_q;
	reg                   lrx_d_q;
	wire [`GPC_IRQ_W-1:0] irq_ev = {lrx_d_q & ~lrx_s, idle_evt, fault_s};

	// mask register and the receiver-ok history for its falling edge
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			irq_mk_q <= {`GPC_IRQ_W{1'b0}};
			lrx_d_q  <= 1'b0;
		end else begin
			lrx_d_q <= lrx_s;
			if (wr_msk)
				irq_mk_q <= i_pwdata[`GPC_IRQ_W-1:0];
		end
	end

	// one sticky bit per event; write one clears, an event in the same cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < `GPC_IRQ_W; gi = gi + 1) begin : g_irq
			reg sticky_q;
			always @(posedge i_clk_sys) begin
				if (i_sys_rst)
					sticky_q <= 1'b0;
				else if (irq_ev[gi])
					sticky_q <= 1'b1;
				else if (wr_isc && i_pwdata[gi])
					sticky_q <= 1'b0;
			end
			assign irq_st[gi] = sticky_q;
		end
	endgenerate

	// level output while any unmasked bit stands
	assign o_irq = |(irq_st & irq_mk_q);

	// read mux, combinational data during the access phase
	always @* begin
		o_prdata = 32'h0000_0000;
		if (rd) begin
			case (i_paddr)
				`GPC_ADDR_GIG_CTRL: o_prdata = {16'h0000, ctrl_q};
				`GPC_ADDR_GIG_STAT: o_prdata = {16'h0000, stat_w};
				`GPC_ADDR_EXT_CTRL: o_prdata = {16'h0000, func_q, 9'h000,
				                                i_target_device_address};
				`GPC_ADDR_EXT_AD:   o_prdata = {16'h0000, ad_addr ? o_ext_addr : i_ext_rdata};
				`GPC_ADDR_IRQ_STAT: o_prdata = {29'h0000_0000, irq_st};
				`GPC_ADDR_IRQ_MASK: o_prdata = {29'h0000_0000, irq_mk_q};
				`GPC_ADDR_PHY_STAT: o_prdata = {30'h0000_0000, link_s, pdown_s};
				default:            o_prdata = 32'h0000_0000;
			endcase
		end
	end
endmodule // gpc_ctrl_status

// [testbench/gpc_ctrl_status_props.sv]
// assertion checker for the gigabit control block
`timescale 1ns/1ps
module gpc_ctrl_status_props (
	input wire logic        i_clk_sys,
	input wire logic        i_sys_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic        i_power_down,
	input wire logic        i_rx_clk_pin,
	input wire logic        i_tx_clk_local,
	input wire logic [2:0]  o_test_mode,
	input wire logic        o_tx_clk_sel_rx,
	input wire logic        o_tx_clk,
	input wire logic        o_ms_manual_en,
	input wire logic        o_ms_manual_master,
	input wire logic        o_want_master,
	input wire logic        o_adv_gig_fd,
	input wire logic        o_adv_gig_hd,
	input wire logic        o_soft_reset,
	input wire logic        o_an_restart,
	input wire logic        o_ext_wr,
	input wire logic        o_ext_rd,
	input wire logic        o_ext_is_addr
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// applied bits may only move around a trigger pulse, not on the write itself
	a_restart_clear: assert property (o_an_restart |-> ##[0:2] o_test_mode == 3'h0)
		else $error("test mode kept after restart");
	a_jitter_sel: assert property (o_tx_clk_sel_rx == (o_test_mode inside {3'h2, 3'h3}))
		else $error("transmit clock select wrong");
	a_tx_clk_src: assert property (o_tx_clk == (o_tx_clk_sel_rx ? i_rx_clk_pin : i_tx_clk_local))
		else $error("transmit clock source wrong");
	a_manual_role: assert property (o_ms_manual_en |-> o_want_master == o_ms_manual_master)
		else $error("manual role not followed");
	// a power-down exit lands five edges after the pin falls, through the synchroniser
	a_fd_pending: assert property (!$stable(o_adv_gig_fd) |->
		o_soft_reset || o_an_restart || $past(o_soft_reset || o_an_restart) ||
		($past(i_power_down, 6) && !$past(i_power_down, 5)))
		else $error("full duplex advert moved without trigger");
	a_role_pending: assert property (!$stable({o_ms_manual_en, o_ms_manual_master,
		o_adv_gig_hd}) |-> o_soft_reset || o_an_restart || $past(o_soft_reset || o_an_restart) ||
		($past(i_power_down, 6) && !$past(i_power_down, 5)))
		else $error("role bits moved without trigger");
	a_ext_rd_src: assert property (o_ext_rd |->
		$past(i_psel && i_penable && !i_pwrite && i_paddr == 12'h038))
		else $error("extended read without access");
	a_ext_wr_src: assert property (o_ext_wr |->
		$past(i_psel && i_penable && i_pwrite && i_paddr == 12'h038))
		else $error("extended write without access");
	a_ext_excl: assert property (!(o_ext_is_addr && (o_ext_wr || o_ext_rd)))
		else $error("address and data access together");
	a_soft_pulse: assert property (o_soft_reset |=> !o_soft_reset)
		else $error("soft reset pulse too long");
endmodule // gpc_ctrl_status_props

bind gpc_ctrl_status gpc_ctrl_status_props u_props (.i_clk_sys, .i_sys_rst, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_power_down, .i_rx_clk_pin, .i_tx_clk_local, .o_test_mode,
	.o_tx_clk_sel_rx, .o_tx_clk, .o_ms_manual_en, .o_ms_manual_master, .o_want_master,
	.o_adv_gig_fd, .o_adv_gig_hd, .o_soft_reset, .o_an_restart, .o_ext_wr, .o_ext_rd,
	.o_ext_is_addr);

// [testbench/gpc_phy_model.sv]
// phy core side: idle error events and extended data locations
`timescale 1ns/1ps
module gpc_phy_model (
	input  wire logic        i_clk_sys,
	input  wire logic [15:0] i_ext_addr,
	output logic      [15:0] o_ext_rdata,
	output logic             o_idle_error
);
	// data location shows inverse of its address, so a stale pointer shows up
	assign o_ext_rdata = ~i_ext_addr;
	initial o_idle_error = 1'h0;
	// each level held three cycles so the input synchroniser sees every edge
	task idle_burst(input int n);
		repeat (n) begin
			repeat (3) @(posedge i_clk_sys);
			o_idle_error <= 1'h1;
			repeat (3) @(posedge i_clk_sys);
			o_idle_error <= 1'h0;
		end
	endtask
endmodule // gpc_phy_model

// [testbench/test_gpc_ctrl_status.sv]
// self-checking bench for the gigabit control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module test_gpc_ctrl_status;
	logic i_clk_sys = 1'h0, i_sys_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
	logic i_ms_fault = 1'h0, i_ms_resolved_master = 1'h0, i_local_rx_ok = 1'h0;
	logic i_remote_rx_ok = 1'h0, i_lp_gig_fd = 1'h0, i_lp_gig_hd = 1'h0, i_rx_clk_pin = 1'h0;
	logic i_copper_link_up = 1'h0, i_power_down = 1'h0, i_tx_clk_local = 1'h1, serr, x0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0000_0000, rdat;
	logic [4:0] i_target_device_address = 5'h15;
	int mismatches = 0, num_checks = 0;
	wire i_idle_error, o_pready, o_pslverr, o_tx_clk_sel_rx, o_tx_clk, o_ms_manual_en;
	wire o_ms_manual_master, o_want_master, o_adv_gig_fd, o_adv_gig_hd, o_soft_reset;
	wire o_an_restart, o_ext_wr, o_ext_rd, o_ext_is_addr, o_irq;
	wire [31:0] o_prdata;
	wire [15:0] i_ext_rdata, o_ext_wdata, o_ext_addr;
	wire [4:0] o_target_device_address;
	wire [2:0] o_test_mode;
	gpc_ctrl_status dut (.i_clk_sys, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_ms_fault, .i_ms_resolved_master,
		.i_local_rx_ok, .i_remote_rx_ok, .i_lp_gig_fd, .i_lp_gig_hd, .i_idle_error,
		.i_copper_link_up, .i_power_down, .i_rx_clk_pin, .i_tx_clk_local,
		.i_target_device_address, .i_ext_rdata, .o_test_mode, .o_tx_clk_sel_rx, .o_tx_clk,
		.o_ms_manual_en, .o_ms_manual_master, .o_want_master, .o_adv_gig_fd, .o_adv_gig_hd,
		.o_soft_reset, .o_an_restart, .o_ext_wr, .o_ext_rd, .o_ext_is_addr, .o_ext_wdata,
		.o_ext_addr, .o_target_device_address, .o_irq);
	gpc_phy_model phy (.i_clk_sys, .i_ext_addr(o_ext_addr), .o_ext_rdata(i_ext_rdata),
		.o_idle_error(i_idle_error));
	always #10 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) i_rx_clk_pin <= ~i_rx_clk_pin;
	// one apb transfer; outputs read at the accepting edge before any update lands
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys);
		i_penable <= 1'h1;
		@(posedge i_clk_sys);
		while (o_pready !== 1'h1) @(posedge i_clk_sys);
		rdat = o_prdata;
		serr = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask
	// command write, then let the trigger settle
	task cmd(input logic [31:0] d);
		ap(1'h1, 12'h040, d);
		repeat (3) @(negedge i_clk_sys);
	endtask
	task t_tmode;
		ap(1'h0, 12'h024, 32'h0000_0000);
		`CHK("ctrl reset", 32'h0000_0200, rdat)
		for (int m = 0; m < 5; m++) begin
			ap(1'h1, 12'h024, {16'h0000, m[2:0], 13'h0200});
			@(negedge i_clk_sys);
			`CHK("test mode", m[2:0], o_test_mode)
			`CHK("clk sel", (m == 2 || m == 3), o_tx_clk_sel_rx)
			`CHK("tx clk", (m == 2 || m == 3) ? i_rx_clk_pin : 1'h1, o_tx_clk)
		end
		cmd(32'h0000_0002);
		ap(1'h0, 12'h024, 32'h0000_0000);
		`CHK("mode cleared", 32'h0000_0200, rdat)
		cmd(32'h0000_0001);
		$display("test modes done");
	endtask
	task t_pend;
		ap(1'h1, 12'h024, 32'h0000_1900);
		repeat (3) @(negedge i_clk_sys);
		`CHK("held bits", 4'h2, {o_ms_manual_en, o_ms_manual_master, o_adv_gig_fd, o_adv_gig_hd})
		cmd(32'h0000_0001);
		`CHK("applied", 4'hd, {o_ms_manual_en, o_ms_manual_master, o_adv_gig_fd, o_adv_gig_hd})
		`CHK("manual master", 1'h1, o_want_master)
		ap(1'h1, 12'h024, 32'h0000_1400);
		cmd(32'h0000_0002);
		`CHK("manual slave", 1'h0, o_want_master)
		ap(1'h1, 12'h024, 32'h0000_0400);
		cmd(32'h0000_0002);
		`CHK("port pref", 1'h1, o_want_master)
		$display("pending bits done");
	endtask
	// power-down exit applies pending bits only while the link is down
	task t_pdown;
		ap(1'h1, 12'h024, 32'h0000_0100);
		@(posedge i_clk_sys);
		i_copper_link_up <= 1'h1;
		i_power_down <= 1'h1;
		repeat (8) @(posedge i_clk_sys);
		ap(1'h0, 12'h04c, 32'h0000_0000);
		`CHK("phy stat", 32'h0000_0003, rdat)
		i_power_down <= 1'h0;
		repeat (8) @(negedge i_clk_sys);
		`CHK("exit link up", 3'h4, {o_want_master, o_adv_gig_fd, o_adv_gig_hd})
		@(posedge i_clk_sys);
		i_copper_link_up <= 1'h0;
		i_power_down <= 1'h1;
		repeat (8) @(posedge i_clk_sys);
		i_power_down <= 1'h0;
		repeat (8) @(negedge i_clk_sys);
		`CHK("exit link down", 3'h1, {o_want_master, o_adv_gig_fd, o_adv_gig_hd})
		$display("power-down exit done");
	endtask
	task t_stat;
		@(posedge i_clk_sys);
		i_ms_fault <= 1'h1;
		i_ms_resolved_master <= 1'h1;
		i_local_rx_ok <= 1'h1;
		i_lp_gig_fd <= 1'h1;
		repeat (8) @(posedge i_clk_sys);
		i_ms_fault <= 1'h0;
		ap(1'h1, 12'h028, 32'h0000_ffff);
		ap(1'h0, 12'h024, 32'h0000_0000);
		ap(1'h0, 12'h028, 32'h0000_0000);
		`CHK("status", 32'h0000_e800, rdat)
		ap(1'h0, 12'h028, 32'h0000_0000);
		`CHK("fault cleared", 32'h0000_6800, rdat)
		$display("status done");
	endtask
	task t_idle;
		phy.idle_burst(3);
		repeat (8) @(negedge i_clk_sys);
		ap(1'h0, 12'h028, 32'h0000_0000);
		`CHK("idle count", 32'h0000_6803, rdat)
		ap(1'h1, 12'h048, 32'h0000_0000);
		@(negedge i_clk_sys);
		x0 = o_irq;
		ap(1'h1, 12'h048, 32'h0000_0007);
		@(negedge i_clk_sys);
		`CHK("irq mask", 1'h1, x0 ^ o_irq)
		ap(1'h1, 12'h044, 32'h0000_0007);
		ap(1'h0, 12'h044, 32'h0000_0000);
		`CHK("irq clear", 32'h0000_0000, rdat)
		phy.idle_burst(260);
		repeat (8) @(negedge i_clk_sys);
		ap(1'h0, 12'h028, 32'h0000_0000);
		`CHK("idle saturate", 32'h0000_68ff, rdat)
		$display("idle count done");
	endtask
	task t_ext;
		logic [15:0] a;
		a = 16'h0010;
		ap(1'h1, 12'h034, 32'h0000_0000);
		ap(1'h1, 12'h038, 32'h0000_0010);
		ap(1'h0, 12'h038, 32'h0000_0000);
		`CHK("ext addr", 32'h0000_0010, rdat)
		for (int f = 1; f < 4; f++) begin
			ap(1'h1, 12'h034, f << 14);
			ap(1'h0, 12'h038, 32'h0000_0000);
			`CHK("ext data", {16'h0000, ~a}, rdat)
			if (f == 2) a++;
			ap(1'h1, 12'h038, 32'h0000_1234);
			@(negedge i_clk_sys);
			if (f > 1) a++;
			`CHK("ext wdata", 16'h1234, o_ext_wdata)
			`CHK("ext ptr", a, o_ext_addr)
			ap(1'h0, 12'h034, 32'h0000_0000);
			`CHK("ext fn", {16'h0000, f[1:0], 14'h0015}, rdat)
		end
		ap(1'h0, 12'h0fc, 32'h0000_0000);
		`CHK("dev addr", 5'h15, o_target_device_address)
		`CHK("unmapped", 33'h1_0000_0000, {serr, rdat})
		$display("extended access done");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_sys_rst <= 1'h0;
		t_tmode;
		t_pend;
		t_pdown;
		t_stat;
		t_idle;
		t_ext;
		report_and_stop;
	end
	// bursts dominate run time, about 1800 cycles
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		mismatches++;
		report_and_stop;
	end
endmodule // test_gpc_ctrl_status
